// File: hvs_pkg.sv
package hvs_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned HOLD_ON_MS = 2000;
  localparam int unsigned BLANK_MS = 4000;
  localparam int unsigned LIMIT_ON_MS = 600_000;
  localparam int unsigned COOL_OFF_MS = 300_000;
  localparam int unsigned SHORT_MS = 30_000;
  localparam int unsigned SD_BEEP_MS = 5000;
  localparam int unsigned BEEP_MS = 200;
  localparam int unsigned GAP_MS = 200;
  localparam logic [2:0] COOL_CYCLES = 3'h5;

  // ----------------------------------------
  // current margins, voltage steps
  // ----------------------------------------
  localparam int unsigned NEAR_SHIFT = 4;
  localparam int unsigned DROP_SHIFT = 2;
  localparam logic [11:0] V_STEP = 12'h0010;

  // ----------------------------------------
  // status codes
  // ----------------------------------------
  localparam logic [7:0] ST_OFF = 8'h00;
  localparam logic [7:0] ST_RUN = 8'h10;
  localparam logic [7:0] ST_COOL = 8'h02;
  localparam logic [7:0] ST_SHUT = 8'h03;
  localparam logic [7:0] ST_ILOCK = 8'h04;

  typedef enum logic [2:0] {
    HVS_OFF,
    HVS_RUN,
    HVS_COOL,
    HVS_SHUT,
    HVS_ILOCK
  } hvs_state_t;

  typedef struct packed {
    logic [11:0] v_max;
    logic [11:0] i_max;
  } hvs_limits_t;

  typedef struct packed {
    logic [7:0] status_code;
    logic [2:0] cooldown_cycle_code;
    logic shutdown_code;
    logic hv_on_led;
    logic show_voltage;
    logic show_current;
  } hvs_display_t;

endpackage

// File: hvs_supervisor.sv
`timescale 1ns/100ps
// Notes on behaviour
// - output on only while ground-sense and cable shield are both intact
// - ground fault forces output off and, outside shut-down, lights the ground fault indicator
// - after a ground fault stay off until intact and button held again
// - turn on only after button held two seconds; then light led, show voltage
// - ramp voltage up toward the configured maximum; load may hold it lower
// - blank current display for a few seconds after turn-on
// - at current limit step the voltage down until current is below limit
// - near-limit current for ten minutes switches off into a cool-down
// - each cool-down holds output off five minutes, then restarts it
// - repeat cycles; after five full cycles enter shut-down
// - current well below limit restarts the sequence, count and timers
// - cool-down shows a code carrying the cycle number one to five
// - entering each cool-down sounds as many short beeps as its number
// - shut-down turns output off, five second beep, shows shut-down code
// - output shorted thirty seconds enters shut-down
// - from shut-down stay off until button held two seconds
// - a configuration switch defeats both cool-down and shut-down
// - button press while on turns output off at once
// - status code off 00, running 10, cooling 02, shut-down 03, interlock 04
module hvs_supervisor
  import hvs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned HOLD_TICKS = HOLD_ON_MS,
  parameter int unsigned BLANK_TICKS = BLANK_MS,
  parameter int unsigned LIMIT_TICKS = LIMIT_ON_MS,
  parameter int unsigned COOL_TICKS = COOL_OFF_MS,
  parameter int unsigned SHORT_TICKS = SHORT_MS,
  parameter int unsigned SD_BEEP_TICKS = SD_BEEP_MS,
  parameter int unsigned BEEP_TICKS = BEEP_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // pins
  input wire logic ground_sense_ok,
  input wire logic shield_ok,
  input wire logic hv_button,
  input wire logic hv_short,
  input wire logic cooldown_defeat,
  // measurements and settings
  input wire logic [11:0] i_meas,
  input wire hvs_limits_t limits,
  // outputs
  output logic hv_enable,
  output logic [11:0] v_set,
  output logic ground_fault_indicator,
  output logic beeper,
  output hvs_display_t disp
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      // ground bits idle intact, no false fault after reset
      sync1_q <= 5'h03;
      sync2_q <= 5'h03;
    end else begin
      sync1_q <= {cooldown_defeat, hv_short, hv_button, shield_ok, ground_sense_ok};
      sync2_q <= sync1_q;
    end
  end
  logic gnd_ok, btn, shorted, defeat;
  assign gnd_ok = sync2_q[0] & sync2_q[1];
  assign btn = sync2_q[2];
  assign shorted = sync2_q[3];
  assign defeat = sync2_q[4];

  // ----------------------------------------
  // common tick
  // ----------------------------------------
  logic [31:0] pre_q;
  logic tick_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (pre_q >= TICK_CYCLES - 1) begin
      pre_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // current thresholds with hysteresis
  // ----------------------------------------
  logic at_lim, near_on, drop_lvl, near_q;
  assign at_lim = i_meas >= limits.i_max;
  assign near_on = i_meas >= limits.i_max - (limits.i_max >> NEAR_SHIFT);
  assign drop_lvl = i_meas < limits.i_max - (limits.i_max >> DROP_SHIFT);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      near_q <= 1'b0;
    end else if (near_on) begin
      near_q <= 1'b1;
    end else if (drop_lvl) begin
      near_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // button press edge and hold counter
  // ----------------------------------------
  logic btn_q;
  logic [31:0] hold_q;
  logic held, press;
  assign press = btn & ~btn_q;
  assign held = btn && hold_q >= HOLD_TICKS;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      btn_q <= 1'b0;
      hold_q <= 32'h0000_0000;
    end else begin
      btn_q <= btn;
      if (!btn || !gnd_ok) begin
        hold_q <= 32'h0000_0000;
      end else if (tick_q && hold_q < HOLD_TICKS) begin
        hold_q <= hold_q + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------
  // supply state machine
  // ----------------------------------------
  hvs_state_t st_q;
  logic [31:0] tmr_q;
  logic [31:0] sht_q;
  logic [2:0] cyc_q;
  logic [3:0] beeps_q;
  logic long_beep_q;
  logic start_beep;
  logic hv_prev_q;
  logic beep_done;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= HVS_OFF;
      tmr_q <= 32'h0000_0000;
      sht_q <= 32'h0000_0000;
      cyc_q <= 3'h0;
      beeps_q <= 4'h0;
      long_beep_q <= 1'b0;
      start_beep <= 1'b0;
    end else begin
      start_beep <= 1'b0;
      if (beep_done) beeps_q <= beeps_q - 4'h1;
      if (!gnd_ok && st_q != HVS_SHUT) begin
        st_q <= HVS_ILOCK;
        cyc_q <= 3'h0;
        tmr_q <= 32'h0000_0000;
      end else begin
        unique case (st_q)
          HVS_OFF, HVS_ILOCK: begin
            if (held) begin
              st_q <= HVS_RUN;
              tmr_q <= 32'h0000_0000;
              sht_q <= 32'h0000_0000;
              cyc_q <= 3'h0;
            end
          end
          HVS_RUN: begin
            if (press && !held) begin
              st_q <= HVS_OFF;
            end else if (!defeat && shorted && sht_q >= SHORT_TICKS) begin
              st_q <= HVS_SHUT;
              long_beep_q <= 1'b1;
              tmr_q <= 32'h0000_0000;
            end else if (defeat || !near_q) begin
              tmr_q <= 32'h0000_0000;
              if (!defeat) cyc_q <= 3'h0;
            end else if (tmr_q >= LIMIT_TICKS) begin
              if (cyc_q >= COOL_CYCLES) begin
                st_q <= HVS_SHUT;
                long_beep_q <= 1'b1;
              end else begin
                st_q <= HVS_COOL;
                cyc_q <= cyc_q + 3'h1;
                beeps_q <= {1'b0, cyc_q + 3'h1};
                start_beep <= 1'b1;
              end
              tmr_q <= 32'h0000_0000;
            end else if (tick_q) begin
              tmr_q <= tmr_q + 32'h0000_0001;
            end
            if (tick_q && shorted) sht_q <= sht_q + 32'h0000_0001;
            else if (!shorted) sht_q <= 32'h0000_0000;
          end
          HVS_COOL: begin
            if (defeat || drop_lvl) begin
              st_q <= HVS_RUN;
              cyc_q <= 3'h0;
              tmr_q <= 32'h0000_0000;
            end else if (tmr_q >= COOL_TICKS) begin
              st_q <= HVS_RUN;
              tmr_q <= 32'h0000_0000;
            end else if (tick_q) begin
              tmr_q <= tmr_q + 32'h0000_0001;
            end
          end
          HVS_SHUT: begin
            if (held && gnd_ok) begin
              st_q <= HVS_RUN;
              cyc_q <= 3'h0;
              sht_q <= 32'h0000_0000;
              tmr_q <= 32'h0000_0000;
            end else if (long_beep_q && tick_q) begin
              if (tmr_q >= SD_BEEP_TICKS - 1) long_beep_q <= 1'b0;
              tmr_q <= tmr_q + 32'h0000_0001;
            end
          end
          default: st_q <= HVS_OFF;
        endcase
      end
    end
  end

  // ----------------------------------------
  // short beep sequencer
  // ----------------------------------------
  logic [31:0] bt_q;
  assign beep_done = tick_q && beeps_q != 4'h0 && bt_q >= 2 * BEEP_TICKS - 1;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bt_q <= 32'h0000_0000;
    end else if (start_beep || beeps_q == 4'h0 || beep_done) begin
      bt_q <= 32'h0000_0000;
    end else if (tick_q) begin
      bt_q <= bt_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // voltage ramp and current limiting
  // ----------------------------------------
  logic running;
  assign running = st_q == HVS_RUN;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      v_set <= 12'h000;
    end else if (!running) begin
      v_set <= 12'h000;
    end else if (v_set > limits.v_max) begin
      v_set <= limits.v_max;
    end else if (tick_q) begin
      if (at_lim) begin
        v_set <= (v_set > V_STEP) ? v_set - V_STEP : 12'h000;
      end else if (v_set < limits.v_max) begin
        v_set <= (limits.v_max - v_set > V_STEP) ? v_set + V_STEP : limits.v_max;
      end
    end
  end

  // ----------------------------------------
  // display blanking after turn-on
  // ----------------------------------------
  logic [31:0] blank_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      blank_q <= 32'h0000_0000;
      hv_prev_q <= 1'b0;
    end else begin
      hv_prev_q <= running;
      if (running && !hv_prev_q) begin
        blank_q <= 32'h0000_0000;
      end else if (tick_q && blank_q < BLANK_TICKS) begin
        blank_q <= blank_q + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hv_enable <= 1'b0;
      ground_fault_indicator <= 1'b0;
      beeper <= 1'b0;
      disp <= '0;
    end else begin
      hv_enable <= running && gnd_ok;
      ground_fault_indicator <= st_q == HVS_ILOCK;
      beeper <= long_beep_q || (beeps_q != 4'h0 && bt_q < BEEP_TICKS);
      disp.hv_on_led <= running;
      disp.show_voltage <= running;
      disp.show_current <= running && blank_q >= BLANK_TICKS;
      disp.cooldown_cycle_code <= (st_q == HVS_COOL) ? cyc_q : 3'h0;
      disp.shutdown_code <= st_q == HVS_SHUT;
      unique case (st_q)
        HVS_RUN: disp.status_code <= ST_RUN;
        HVS_COOL: disp.status_code <= ST_COOL;
        HVS_SHUT: disp.status_code <= ST_SHUT;
        HVS_ILOCK: disp.status_code <= ST_ILOCK;
        default: disp.status_code <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  gnd_off_a: assert property (@(posedge clock) disable iff (!rst_b)
    !gnd_ok |-> ##2 !hv_enable) else $error("hv on without ground");
  ind_on_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_q == HVS_ILOCK |=> ground_fault_indicator) else $error("indicator dark");
  no_auto_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_q == HVS_ILOCK && !held |=> st_q != HVS_RUN) else $error("auto restart");
  hold_req_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(running) && $past(st_q) != HVS_COOL |-> $past(held) || $past(st_q) == HVS_RUN)
    else $error("on without hold");
  quick_off_a: assert property (@(posedge clock) disable iff (!rst_b)
    running && press && !held && gnd_ok |=> st_q == HVS_OFF) else $error("slow off");
  ramp_cap_a: assert property (@(posedge clock) disable iff (!rst_b)
    running && !at_lim && $stable(limits.v_max) |=> v_set <= limits.v_max)
    else $error("ramp overshoot");
  cool_code_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_q == HVS_COOL |-> cyc_q >= 3'h1 && cyc_q <= COOL_CYCLES) else $error("bad cycle");
  defeat_a: assert property (@(posedge clock) disable iff (!rst_b)
    defeat && running |=> st_q != HVS_COOL) else $error("defeat ignored");
  stat_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_q == HVS_SHUT ##1 st_q == HVS_SHUT |-> disp.status_code == ST_SHUT)
    else $error("bad status");
  sequence cool_entry_s;
    st_q == HVS_RUN ##1 st_q == HVS_COOL;
  endsequence
  sequence shut_entry_s;
    st_q != HVS_SHUT ##1 st_q == HVS_SHUT;
  endsequence
  beep_cnt_a: assert property (@(posedge clock) disable iff (!rst_b)
    cool_entry_s |-> beeps_q == {1'b0, cyc_q}) else $error("wrong beep count");
  sd_beep_a: assert property (@(posedge clock) disable iff (!rst_b)
    shut_entry_s |-> long_beep_q ##1 beeper) else $error("no shut-down beep");
  sd_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    st_q == HVS_SHUT && !held |=> st_q == HVS_SHUT) else $error("left shut-down");
  seq_reset_a: assert property (@(posedge clock) disable iff (!rst_b)
    running && !near_q && !defeat && !press && !shorted |=> cyc_q == 3'h0)
    else $error("sequence not reset");

endmodule

// File: hvs_pump.sv
`timescale 1ns/100ps
module hvs_pump (
  // stage drive
  input wire logic hv_enable,
  input wire logic [11:0] v_set,
  // load selection
  input wire logic heavy,
  input wire logic short_cmd,
  // sensed back
  output logic [11:0] i_meas,
  output logic hv_short
);
  // ----------------------------------------
  // load
  // ----------------------------------------
  // heavy load stays near the limit, even while the stage is off
  always_comb begin
    if (heavy) begin
      i_meas = 12'h01e0 + (v_set >> 4);
    end else begin
      i_meas = hv_enable ? (v_set >> 4) : 12'h0000;
    end
    hv_short = short_cmd;
  end
endmodule

// File: hv_supply_supervisor_tb.sv
`timescale 1ns/100ps
module hv_supply_supervisor_tb;
  import hvs_pkg::*;
  localparam int TC = 4;
  localparam int HT = 5;
  localparam int BT = 6;
  localparam int LT = 40;
  localparam int CT = 40;
  localparam int ST = 8;
  localparam int SDT = 8;
  localparam int BPT = 2;
  logic clock = 0, rst_b = 0, gnd_ok = 1, shield_ok = 1, hv_button = 0;
  logic defeat = 0, heavy = 0, short_cmd = 0, hv_short, hv_enable, gfi, beeper;
  logic bp_q = 0, en_q = 0;
  logic [11:0] i_meas, v_set, vpk;
  hvs_limits_t limits;
  hvs_display_t disp;
  int err_count = 0, compares = 0, seed = 32'hcec4a35f, n, k, m, beeps, bhi, bmax;
  logic [7:0] exp_code[5] = '{8'h00, 8'h10, 8'h02, 8'h03, 8'h04};
  always #5 clock = ~clock;
  hvs_supervisor #(.TICK_CYCLES(TC), .HOLD_TICKS(HT), .BLANK_TICKS(BT), .LIMIT_TICKS(LT),
    .COOL_TICKS(CT), .SHORT_TICKS(ST), .SD_BEEP_TICKS(SDT), .BEEP_TICKS(BPT)) DUT (
    .clock(clock), .rst_b(rst_b), .ground_sense_ok(gnd_ok), .shield_ok(shield_ok),
    .hv_button(hv_button), .hv_short(hv_short), .cooldown_defeat(defeat),
    .i_meas(i_meas), .limits(limits), .hv_enable(hv_enable), .v_set(v_set),
    .ground_fault_indicator(gfi), .beeper(beeper), .disp(disp));
  hvs_pump pump (.hv_enable(hv_enable), .v_set(v_set), .heavy(heavy),
    .short_cmd(short_cmd), .i_meas(i_meas), .hv_short(hv_short));
  // ----------------------------------------
  // observers
  // ----------------------------------------
  always @(negedge clock) begin
    if (hv_enable === 1'b0 && en_q === 1'b1) beeps = 0;
    if (beeper === 1'b1 && bp_q === 1'b0) beeps++;
    bhi = (beeper === 1'b1) ? bhi + 1 : 0;
    if (bhi > bmax) bmax = bhi;
    if (hv_enable === 1'b1 && v_set > vpk) vpk = v_set;
    bp_q = beeper;
    en_q = hv_enable;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // elapsed cycles against a tick count, one tick of slack below, one tick and six cycles above
  task automatic chk_t(input int g, input int t);
    compares++;
    if (g < (t - 1) * TC || g > (t + 1) * TC + 6) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, t * TC);
    end
  endtask
  task automatic wait_en(input logic v, input int lim);
    n = 0;
    while (hv_enable !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic hold_on();
    hv_button = 1;
    wait_en(1, (HT + 3) * TC + 20);
    hv_button = 0;
    cyc(4);
  endtask
  task automatic test_done();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    err_count++;
    test_done();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    limits = '{v_max: 12'h0200 + (12'($random(seed)) & 12'h01f0), i_max: 12'h0200};
    cyc(2);
    rst_b = 1;
    cyc(1);
    chk(hv_enable, 16'h0000);
    chk(disp.status_code, exp_code[0]);
    for (k = 0; k < 2; k++) begin
      gnd_ok = k[0];
      shield_ok = !k;
      hv_button = 1;
      cyc((HT + 3) * TC);
      chk(hv_enable, 16'h0000);
      hv_button = 0;
      gnd_ok = 1;
      shield_ok = 1;
      cyc(4);
    end
    hold_on();
    chk_t(n, HT);
    chk({disp.hv_on_led, disp.show_voltage, disp.show_current}, 3'h6);
    chk(disp.status_code, exp_code[1]);
    cyc(70 * TC);
    chk(v_set, limits.v_max);
    chk(disp.show_current, 16'h0001);
    hv_button = 1;
    cyc(5);
    chk(hv_enable, 16'h0000);
    chk(disp.status_code, exp_code[0]);
    hv_button = 0;
    cyc(4);
    hold_on();
    shield_ok = 0;
    cyc(5);
    chk({hv_enable, gfi}, 2'h1);
    chk(disp.status_code, exp_code[4]);
    shield_ok = 1;
    cyc(20 * TC);
    chk(hv_enable, 16'h0000);
    hold_on();
    chk({hv_enable, gfi}, 2'h2);
    bmax = 0;
    short_cmd = 1;
    wait_en(0, (ST + 3) * TC);
    chk_t(n, ST);
    short_cmd = 0;
    cyc(2);
    chk({disp.status_code, disp.shutdown_code}, {exp_code[3], 1'b1});
    hv_button = 1;
    cyc(TC * 2);
    hv_button = 0;
    cyc((SDT + 2) * TC);
    chk_t(bmax, SDT);
    chk(hv_enable, 16'h0000);
    hold_on();
    chk(hv_enable, 16'h0001);
    defeat = 1;
    short_cmd = 1;
    heavy = 1;
    cyc((LT + ST + 4) * TC);
    chk(hv_enable, 16'h0001);
    {defeat, short_cmd, heavy} = 3'h1;
    limits.v_max = 12'h0800;
    vpk = 0;
    m = 0;
    for (k = 0; k < 8; k++) begin
      if (k == 2) begin
        heavy = 0;
        cyc(LT * TC / 2);
        heavy = 1;
        m = 0;
      end
      wait_en(0, (LT + 3) * TC + 8);
      chk_t(n, LT);
      m++;
      cyc(2);
      if (m < 6) begin
        chk(disp.cooldown_cycle_code, 16'(m));
        chk(disp.status_code, exp_code[2]);
        wait_en(1, (CT + 3) * TC + 8);
        chk_t(n, CT);
        chk(16'(beeps), 16'(m));
      end else begin
        chk({disp.status_code, disp.shutdown_code}, {exp_code[3], 1'b1});
      end
    end
    chk(vpk < 12'h0240, 16'h0001);
    rst_b = 0;
    cyc(2);
    rst_b = 1;
    cyc(1);
    chk({disp.status_code, disp.shutdown_code, gfi, beeper, hv_enable}, 16'h0000);
    cyc(4);
    chk({gfi, v_set}, 16'h0000);
    chk(disp.status_code, exp_code[0]);
    test_done();
  end
endmodule
